// [common/lfs_pkg.sv]
// constants and carrier types of the led fault supervisor
// assumes a single 50 MHz core clock and an apb register port
package lfs_pkg;

  // ==========================================================
  // timing
  // ==========================================================
  localparam int CLK_NS = 20; // core clock period
  localparam int SG_DEG_NS = 20000; // ground_short_deglitch
  localparam int OPEN_DEG_NS = 20000; // open-circuit deglitch
  localparam int TSD_DEG_NS = 40000; // thermal_deglitch
  localparam int RECOV_NS = 200000; // fault-recovery delay
  localparam int SG_DEG_CYC = (SG_DEG_NS + CLK_NS - 1) / CLK_NS;
  localparam int OPEN_DEG_CYC = (OPEN_DEG_NS + CLK_NS - 1) / CLK_NS;
  localparam int TSD_DEG_CYC = (TSD_DEG_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOV_CYC_DEF = (RECOV_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] CTRL_OFS = 8'h00; // control
  localparam logic [7:0] STATE_OFS = 8'h04; // live state
  localparam logic [7:0] ISTAT_OFS = 8'h08; // sticky events, w1c
  localparam logic [7:0] IMASK_OFS = 8'h0C; // event mask
  localparam int CTRL_EN_BIT = 0; // global run enable
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] IMASK_RST = 32'h0000_0000;
  localparam int EV_W = 5; // event count
  localparam int EV_SHORT = 0; // ground short detected
  localparam int EV_OPEN = 1; // open circuit detected
  localparam int EV_OT = 2; // overtemperature detected
  localparam int EV_EXT = 3; // bus pulled low by another party
  localparam int EV_RECOV = 4; // recovery complete
  localparam int ST_CHF = 0; // state: channel faults [2:0]
  localparam int ST_OT = 3; // state: overtemperature
  localparam int ST_BUSLOW = 4; // state: fault line low
  localparam int ST_HOLD = 5; // state: outputs held off
  localparam int ST_LOWPWR = 6; // state: fault mode

  // ==========================================================
  // carriers
  // ==========================================================
  typedef struct packed {
    logic supply_ok_in; // supply above power-on rising threshold
    logic fault_line_in; // level seen on the shared fault line
    logic over_temp_in; // junction above thermal_shutdown_limit
    logic diag_enable_in; // open detection enable
    logic [2:0] channel_dim_in; // per-channel dimming input
    logic [2:0] ground_short_in; // output below ground_short_threshold
    logic [2:0] open_in; // open or short-to-supply sensed
  } lfs_pin_t;

  localparam lfs_pin_t PIN_RST = '{supply_ok_in: 1'b0, fault_line_in: 1'b1, over_temp_in: 1'b0,
    diag_enable_in: 1'b0, channel_dim_in: 3'h0, ground_short_in: 3'h0, open_in: 3'h0};

  typedef struct packed {
    logic [2:0] ch_on; // channel regulating at set current
    logic [2:0] ch_retry; // channel driven with retry current
    logic low_power; // fault mode, reduced supply use
  } lfs_drv_t;

endpackage : lfs_pkg

// [design/lfs_supervisor.sv]
// fault supervisor of a three-channel led driver, with apb registers
// assumes analog comparators deliver levels asynchronous to CORE_CLK
//
// How it works
// - diag low ignores open and supply shorts
// - deglitched ground short forces retry current
// - deglitched overtemperature turns all channels off
// - line low with own fault: retry failed
// - after line release wait recovery then on
// - line low, no own fault: all off
// - below power-on threshold everything disabled
// - fault pulls line; low line enters fault mode
// - diag high enables open detection
// - channels not retrying stay off until line high again and the recovery delay has passed

// ============================================================
// three-stage input synchroniser with agreement filter
// ============================================================
module lfs_sync #(
  parameter int W = 1, // width
  parameter logic [W-1:0] RST = '0 // reset level
) (
  input wire logic clk, // core clock
  input wire logic nrst, // async reset, low
  input wire logic [W-1:0] d, // asynchronous level
  output logic [W-1:0] q // filtered level
);
  logic [W-1:0] s1_reg; // first stage, read by s2 only
  logic [W-1:0] s2_reg; // second stage
  logic [W-1:0] s3_reg; // third stage

  // shift chain; a change counts once stage two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= RST;
      s2_reg <= RST;
      s3_reg <= RST;
      q <= RST;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule : lfs_sync

// ============================================================
// restarting deglitch counter
// ============================================================
module lfs_deglitch #(
  parameter int CNT = 4 // cycles the condition must hold
) (
  input wire logic clk, // core clock
  input wire logic nrst, // async reset, low
  input wire logic cond, // qualifying condition
  output logic done // condition held CNT cycles
);
  localparam int CW = $clog2(CNT + 1); // counter width
  logic [CW-1:0] cnt_reg; // cycles seen so far

  // count while the condition stands, restart whenever it drops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
      done <= 1'b0;
    end else if (!cond) begin
      cnt_reg <= '0;
      done <= 1'b0;
    end else if (cnt_reg < CW'(CNT - 1)) begin
      cnt_reg <= cnt_reg + CW'(1);
    end else begin
      done <= 1'b1;
    end
  end
endmodule : lfs_deglitch

// ============================================================
// top
// ============================================================
module lfs_supervisor #(
  parameter int RECOV_CYC = lfs_pkg::RECOV_CYC_DEF // recovery delay in cycles
) (
  input wire logic CORE_CLK, // core clock, 50 MHz
  input wire logic NRST, // async reset, low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction
  input wire logic [7:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error, unmapped address
  input wire lfs_pkg::lfs_pin_t PIN_IN, // analog and pin levels
  output logic FAULT_OUT, // fault line drive value, always low
  output logic FAULT_OE, // fault line sink enable
  output lfs_pkg::lfs_drv_t DRV_OUT, // channel drive
  output logic IRQ // interrupt, level
);
  import lfs_pkg::*;

  // ==========================================================
  // input synchronisation
  // ==========================================================
  lfs_pin_t pin; // filtered pins

  lfs_sync #(.W($bits(lfs_pin_t)), .RST(PIN_RST)) u_sync (
    .clk(CORE_CLK),
    .nrst(NRST),
    .d(PIN_IN),
    .q(pin)
  );

  logic [31:0] ctrl_reg; // control register
  logic [EV_W-1:0] istat_reg; // sticky events
  logic [EV_W-1:0] imask_reg; // event mask
  logic [2:0] short_reg; // per-channel ground short latched
  logic [2:0] open_reg; // per-channel open latched
  logic ot_reg; // overtemperature latched
  logic hold_reg; // outputs held off by the fault line
  logic run; // supply good and enabled
  logic own_fault; // any fault of this device
  logic bus_low; // fault line seen low
  logic [2:0] sg_done; // short deglitch expired
  logic [2:0] op_done; // open deglitch expired
  logic [2:0] sg_cond; // short qualifying condition
  logic [2:0] op_cond; // open qualifying condition
  logic ot_done; // thermal deglitch expired
  logic rec_done; // recovery delay expired

  assign run = pin.supply_ok_in & ctrl_reg[CTRL_EN_BIT];
  assign bus_low = ~pin.fault_line_in;
  assign own_fault = (|short_reg) | (|open_reg) | ot_reg;

  // ==========================================================
  // channel detectors
  // ==========================================================
  for (genvar i = 0; i < 3; i++) begin : g_ch
    // a retrying channel is judged regardless of its dimming input
    assign sg_cond[i] = run & pin.ground_short_in[i] & (pin.channel_dim_in[i] | short_reg[i]);
    // open sensing only counts with diagnostics on
    assign op_cond[i] = run & pin.diag_enable_in & pin.open_in[i] & (pin.channel_dim_in[i] | open_reg[i]);

    lfs_deglitch #(.CNT(SG_DEG_CYC)) u_sg (
      .clk(CORE_CLK),
      .nrst(NRST),
      .cond(sg_cond[i]),
      .done(sg_done[i])
    );

    lfs_deglitch #(.CNT(OPEN_DEG_CYC)) u_op (
      .clk(CORE_CLK),
      .nrst(NRST),
      .cond(op_cond[i]),
      .done(op_done[i])
    );
  end

  lfs_deglitch #(.CNT(TSD_DEG_CYC)) u_ot (
    .clk(CORE_CLK),
    .nrst(NRST),
    .cond(run & pin.over_temp_in),
    .done(ot_done)
  );

  // recovery counts only while the line is released after a hold
  lfs_deglitch #(.CNT(RECOV_CYC)) u_rec (
    .clk(CORE_CLK),
    .nrst(NRST),
    .cond(hold_reg & ~bus_low),
    .done(rec_done)
  );

  // ==========================================================
  // fault latches
  // ==========================================================
  // a fault stands while its condition stands, then clears by itself
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      short_reg <= 3'h0;
      open_reg <= 3'h0;
      ot_reg <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        // a dropped condition clears the latch at once, even if done is still high
        short_reg[i] <= sg_cond[i] & (sg_done[i] | short_reg[i]);
        open_reg[i] <= op_cond[i] & (op_done[i] | open_reg[i]);
      end
      ot_reg <= ot_done | (ot_reg & run & pin.over_temp_in);
    end
  end

  // line hold: set while the line is low, ends after recovery delay
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      hold_reg <= 1'b0;
    end else if (bus_low) begin
      hold_reg <= 1'b1;
    end else if (rec_done) begin
      hold_reg <= 1'b0;
    end
  end

  // ==========================================================
  // channel and fault line drive
  // ==========================================================
  // healthy channels follow dimming unless held; failed ones retry
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      DRV_OUT <= '0;
      FAULT_OUT <= 1'b0;
      FAULT_OE <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        DRV_OUT.ch_on[i] <= run & ~ot_reg & ~hold_reg & ~bus_low & pin.channel_dim_in[i] &
          ~short_reg[i] & ~open_reg[i];
        DRV_OUT.ch_retry[i] <= run & ~ot_reg & (short_reg[i] | open_reg[i]);
      end
      DRV_OUT.low_power <= own_fault & bus_low;
      FAULT_OUT <= 1'b0;
      FAULT_OE <= own_fault;
    end
  end

  // ==========================================================
  // events and interrupt
  // ==========================================================
  logic [EV_W-1:0] ev; // one-cycle events
  logic hold_q; // hold_reg delayed
  logic ext_q; // external low delayed
  logic [2:0] short_q; // short_reg delayed
  logic [2:0] open_q; // open_reg delayed
  logic ot_q; // ot_reg delayed
  logic ev_wr; // w1c write to event status

  assign ev[EV_SHORT] = |(short_reg & ~short_q);
  assign ev[EV_OPEN] = |(open_reg & ~open_q);
  assign ev[EV_OT] = ot_reg & ~ot_q;
  // a low line seen during our own hold is not blamed on another party,
  // since our released sink still reads low for a few filter cycles
  assign ev[EV_EXT] = (bus_low & ~own_fault & ~hold_reg) & ~ext_q;
  assign ev[EV_RECOV] = hold_q & ~hold_reg;

  // edge history for event detection
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      short_q <= 3'h0;
      open_q <= 3'h0;
      ot_q <= 1'b0;
      hold_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      short_q <= short_reg;
      open_q <= open_reg;
      ot_q <= ot_reg;
      hold_q <= hold_reg;
      ext_q <= bus_low & ~own_fault & ~hold_reg;
    end
  end

  // writes take effect at the edge where the master sees PREADY high
  assign ev_wr = PSEL & PENABLE & PREADY & PWRITE & (PADDR == ISTAT_OFS);

  // sticky status; a new event wins over a clearing write
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      istat_reg <= '0;
    end else if (ev_wr) begin
      istat_reg <= (istat_reg & ~PWDATA[EV_W-1:0]) | ev;
    end else begin
      istat_reg <= istat_reg | ev;
    end
  end

  // interrupt level from unmasked status
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(istat_reg & imask_reg);
    end
  end

  // ==========================================================
  // apb slave: one wait state, answer on second access cycle
  // ==========================================================
  logic acc; // access cycle, not yet answered
  logic mapped; // address decodes
  logic [31:0] rd; // read mux

  assign acc = PSEL & PENABLE & ~PREADY;
  assign mapped = (PADDR == CTRL_OFS) | (PADDR == STATE_OFS) | (PADDR == ISTAT_OFS) | (PADDR == IMASK_OFS);

  // read data selection
  always_comb begin
    rd = 32'h0000_0000;
    case (PADDR)
      CTRL_OFS: rd = ctrl_reg;
      STATE_OFS: begin
        rd[ST_CHF +: 3] = short_reg | open_reg;
        rd[ST_OT] = ot_reg;
        rd[ST_BUSLOW] = bus_low;
        rd[ST_HOLD] = hold_reg;
        rd[ST_LOWPWR] = DRV_OUT.low_power;
      end
      ISTAT_OFS: rd[EV_W-1:0] = istat_reg;
      IMASK_OFS: rd[EV_W-1:0] = imask_reg;
      default: rd = 32'h0000_0000;
    endcase
  end

  // writable registers
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_reg <= CTRL_RST;
      imask_reg <= IMASK_RST[EV_W-1:0];
    end else if (PSEL & PENABLE & PREADY & PWRITE) begin
      if (PADDR == CTRL_OFS) begin
        ctrl_reg <= {31'h0000_0000, PWDATA[CTRL_EN_BIT]};
      end
      if (PADDR == IMASK_OFS) begin
        imask_reg <= PWDATA[EV_W-1:0];
      end
    end
  end

  // handshake and read data
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= acc;
      PSLVERR <= acc & ~mapped;
      PRDATA <= (acc & ~PWRITE) ? rd : 32'h0000_0000;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  sequence s_short_held;
    sg_cond[0] ##1 sg_cond[0];
  endsequence

  a_diag_gate_open: assert property (!pin.diag_enable_in |=> open_reg == 3'h0)
    else $error("open fault without diagnostics");
  a_short_deglitch: assert property ($rose(short_reg[0]) |-> $past(sg_cond[0]) && $past(sg_cond[0], 2))
    else $error("short latched before deglitch");
  a_short_retry: assert property (s_short_held ##0 short_reg[0] && run && !ot_reg |=> DRV_OUT.ch_retry[0])
    else $error("failed channel not retried");
  a_fault_sink: assert property (own_fault |=> FAULT_OE && !FAULT_OUT)
    else $error("fault line not sunk");
  a_thermal_off: assert property (ot_reg |=> DRV_OUT.ch_on == 3'h0)
    else $error("channel on in overtemperature");
  a_ext_low_off: assert property (bus_low && !own_fault |=> DRV_OUT.ch_on == 3'h0)
    else $error("channel on while line low");
  a_recov_wait: assert property ($fell(hold_reg) |-> $past(rec_done) && $past(!bus_low, 2))
    else $error("hold released early");
  a_hold_line: assert property (bus_low |=> hold_reg)
    else $error("hold not set on low line");
  a_por_off: assert property (!pin.supply_ok_in |=> DRV_OUT.ch_on == 3'h0 && DRV_OUT.ch_retry == 3'h0)
    else $error("drive active below power-on");
  sequence s_mode_entered;
    DRV_OUT.low_power && FAULT_OE;
  endsequence

  a_fault_mode: assert property (own_fault && bus_low |=> s_mode_entered)
    else $error("fault mode not entered");

endmodule : lfs_supervisor

// [tb/lfs_bus_peer.sv]
// another led driver hanging on the shared fault line
// assumes the line has a weak pull-up, so it reads high when nobody sinks it
module lfs_bus_peer (
  input wire logic clk, // core clock
  input wire logic fault_req, // this peer has a fault of its own
  input wire logic dut_oe, // design sinks the line
  output logic line // resolved line level
);
  timeunit 1ns;
  timeprecision 1ps;

  logic sink_reg; // peer sink enable

  // ============================================================
  // peer drive
  // ============================================================
  // the peer changes its sink only just after a clock edge
  always_ff @(posedge clk) begin
    sink_reg <= fault_req;
  end

  // wired line: any sink wins, else the pull-up lifts it
  assign line = !(sink_reg || dut_oe);
endmodule : lfs_bus_peer

// [tb/lfs_supervisor_tb_top.sv]
// self-checking bench of the led fault supervisor
// assumes a 50 MHz clock, apb access and one peer driver on the fault line
module lfs_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lfs_pkg::*;

  localparam int RECOV = 20; // shortened recovery delay
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr; // clock, reset, apb
  logic [7:0] paddr; // apb address
  logic [31:0] pwdata, prdata, rd; // apb data
  logic fault_out, fault_oe, irq, peer_fault, line, err; // line and status
  lfs_pin_t pin, pin_dut; // pin levels
  lfs_drv_t drv; // channel drive
  int n_fail, n_compared; // counters

  // ============================================================
  // structure
  // ============================================================
  // the fault line level comes back from the resolved wire
  always_comb begin
    pin_dut = pin;
    pin_dut.fault_line_in = line;
  end

  lfs_supervisor #(.RECOV_CYC(RECOV)) u_lfs_supervisor (.CORE_CLK(core_clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PIN_IN(pin_dut), .FAULT_OUT(fault_out), .FAULT_OE(fault_oe), .DRV_OUT(drv), .IRQ(irq));
  lfs_bus_peer u_lfs_bus_peer (.clk(core_clk), .fault_req(peer_fault), .dut_oe(fault_oe), .line(line));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ============================================================
  // tasks
  // ============================================================
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  // wait whole cycles, then let that edge's updates settle
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wt

  // one apb transfer; data and response are taken at the edge pready is high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // sample pready at each rising edge; take the answer at that same edge
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      $display("Error apb_ready expected 1 seen 0");
    end
  endtask : apb

  task automatic reg_chk(input string name, input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd & msk);
  endtask : reg_chk

  // ============================================================
  // watchdog
  // ============================================================
  initial begin
    repeat (40000) @(posedge core_clk);
    n_fail++;
    end_of_test();
  end

  // ============================================================
  // test sequence
  // ============================================================
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    peer_fault = 1'b0;
    n_fail = 0;
    n_compared = 0;
    pin = PIN_RST; // controller keeps dim and diag low while supply is down
    pin.over_temp_in = 1'b1;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    // hot die while unpowered must raise nothing
    wt(TSD_DEG_CYC + 20);
    chk("oe_unpowered", 32'h0, 32'(fault_oe));
    reg_chk("ctrl_rst", CTRL_OFS, 32'hFFFFFFFF, CTRL_RST);
    reg_chk("imask_rst", IMASK_OFS, 32'hFFFFFFFF, IMASK_RST);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", 32'h1, 32'(err));
    chk("unmapped_rd", 32'h0, rd);
    apb(1'b1, STATE_OFS, 32'hFFFFFFFF);
    reg_chk("state_ro", STATE_OFS, 32'hFFFFFFFF, 32'h0);
    @(posedge core_clk);
    pin.over_temp_in <= 1'b0;
    pin.supply_ok_in <= 1'b1;
    pin.channel_dim_in <= 3'h7;
    wt(20);
    chk("on_powered", 32'h7, 32'(drv.ch_on));
    apb(1'b1, CTRL_OFS, 32'h0);
    wt(3);
    chk("on_disabled", 32'h0, 32'(drv.ch_on));
    apb(1'b1, CTRL_OFS, 32'h1);
    wt(10);
    // open on channel 1, first with diagnostics off
    @(posedge core_clk);
    pin.open_in <= 3'h2;
    wt(OPEN_DEG_CYC + 100);
    chk("on_diag_low", 32'h7, 32'(drv.ch_on));
    chk("oe_diag_low", 32'h0, 32'(fault_oe));
    @(posedge core_clk);
    pin.diag_enable_in <= 1'b1;
    wt(OPEN_DEG_CYC + 20);
    chk("retry_open", 32'h2, 32'(drv.ch_retry));
    chk("oe_open", 32'h1, 32'(fault_oe));
    chk("on_open", 32'h0, 32'(drv.ch_on));
    @(posedge core_clk);
    pin.open_in <= 3'h0;
    wt(10);
    chk("on_wait_recov", 32'h0, 32'(drv.ch_on));
    wt(40);
    chk("on_recov_open", 32'h7, 32'(drv.ch_on));
    reg_chk("istat_open", ISTAT_OFS, 32'h12, 32'h12);
    apb(1'b1, ISTAT_OFS, 32'hFFFFFFFF);
    reg_chk("istat_w1c", ISTAT_OFS, 32'hFFFFFFFF, 32'h0);
    // ground short on channel 0 with a glitch that restarts the count
    @(posedge core_clk);
    pin.ground_short_in <= 3'h1;
    wt(SG_DEG_CYC - 100);
    @(posedge core_clk);
    pin.ground_short_in <= 3'h0;
    wt(10);
    @(posedge core_clk);
    pin.ground_short_in <= 3'h1;
    wt(SG_DEG_CYC - 100);
    chk("oe_restart", 32'h0, 32'(fault_oe));
    wt(120);
    chk("retry_short", 32'h1, 32'(drv.ch_retry));
    chk("on_short", 32'h0, 32'(drv.ch_on));
    chk("low_power", 32'h1, 32'(drv.low_power));
    chk("oe_short", 32'h1, 32'(fault_oe));
    chk("fault_out", 32'h0, 32'(fault_out));
    reg_chk("state_short", STATE_OFS, 32'h7F, 32'h71);
    @(posedge core_clk);
    pin.channel_dim_in <= 3'h6;
    wt(20);
    chk("retry_no_dim", 32'h1, 32'(drv.ch_retry));
    @(posedge core_clk);
    pin.ground_short_in <= 3'h0;
    pin.channel_dim_in <= 3'h7;
    wt(60);
    chk("on_recov_short", 32'h7, 32'(drv.ch_on));
    // interrupt raised, masked and cleared
    apb(1'b1, IMASK_OFS, 32'h1);
    wt(3);
    chk("irq_raised", 32'h1, 32'(irq));
    apb(1'b1, IMASK_OFS, 32'h0);
    wt(3);
    chk("irq_masked", 32'h0, 32'(irq));
    apb(1'b1, ISTAT_OFS, 32'hFFFFFFFF);
    apb(1'b1, IMASK_OFS, 32'h1);
    wt(3);
    chk("irq_cleared", 32'h0, 32'(irq));
    // overtemperature switches every channel off
    @(posedge core_clk);
    pin.over_temp_in <= 1'b1;
    wt(TSD_DEG_CYC + 20);
    chk("on_hot", 32'h0, 32'(drv.ch_on));
    chk("oe_hot", 32'h1, 32'(fault_oe));
    reg_chk("istat_ot", ISTAT_OFS, 32'h4, 32'h4);
    @(posedge core_clk);
    pin.over_temp_in <= 1'b0;
    wt(60);
    chk("on_cool", 32'h7, 32'(drv.ch_on));
    // another driver sinks the line
    @(posedge core_clk);
    peer_fault <= 1'b1;
    wt(10);
    chk("on_ext", 32'h0, 32'(drv.ch_on));
    chk("oe_ext", 32'h0, 32'(fault_oe));
    reg_chk("istat_ext", ISTAT_OFS, 32'h8, 32'h8);
    @(posedge core_clk);
    peer_fault <= 1'b0;
    wt(10);
    chk("on_ext_hold", 32'h0, 32'(drv.ch_on));
    wt(40);
    chk("on_ext_recov", 32'h7, 32'(drv.ch_on));
    end_of_test();
  end
endmodule : lfs_supervisor_tb_top
